//--- hw/rmp_pkg.sv
// Constants for the muxed host bus port of the real-time clock.
// Assumes a 25 MHz core clock and a 32.768 kHz timebase made from it.
package rmp_pkg;
  // Core clock and derived timebase
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned OSC_HZ = 32_768;
  localparam logic [24:0] PHASE_STEP = 25'(OSC_HZ);
  localparam logic [24:0] PHASE_WRAP = 25'(CLK_HZ);
  localparam int DIV_W = 15;

  // Address map: 14 clock/control bytes, then 114 storage bytes
  localparam int ADDR_W = 7;
  localparam int CLOCK_BYTES = 14;
  localparam int STORE_BYTES = 114;
  localparam int MEM_BYTES = CLOCK_BYTES + STORE_BYTES;
  localparam logic [6:0] RATE_CTRL_ADDR = 7'h0A;
  localparam logic [6:0] MODE_CTRL_ADDR = 7'h0B;
  localparam logic [6:0] EVENT_STAT_ADDR = 7'h0C;

  // Rate control field
  localparam int RATE_LSB = 0;
  localparam int RATE_W = 4;

  // Mode control fields
  localparam int WAVE_EN_BIT = 3;
  localparam int UPD_EN_BIT = 4;
  localparam int ALARM_EN_BIT = 5;
  localparam int PER_EN_BIT = 6;
  localparam logic [7:0] MODE_RESET_MASK = 8'h87;

  // Event status fields
  localparam int UPD_FLAG_BIT = 4;
  localparam int ALARM_FLAG_BIT = 5;
  localparam int PER_FLAG_BIT = 6;
  localparam int IRQ_SUM_BIT = 7;
  localparam logic [7:0] EVENT_RESET = 8'h00;

  // Synchroniser vector layout
  localparam int SYNC_W = 16;

  typedef enum logic [1:0] {
    XFER_IDLE = 2'b01,
    XFER_READ = 2'b10
  } rmp_xfer_t;
endpackage : rmp_pkg

//--- hw/rmp_host_port.sv
// Host bus port of the real-time clock: muxed address/data, two strobe styles,
// open-drain interrupt, square-wave output and external RAM enable gating.
// Assumes all other pins are asynchronous and alarm/update events come as core pulses.
// How it works
// - Address phase always precedes data phase.
// - Latch address on strobe falling edge.
// - Address latch ignores device select.
// - Style select: high combined, low separate.
// - Separate style: drive bus at strobe fall.
// - Separate style: write on write-strobe rise.
// - Combined style: drive after strobe rise.
// - Combined style: write at strobe fall.
// - Combined style: direction level gives read/write.
// - Interrupt open-drain, low on enabled flag.
// - Status read releases interrupt output.
// - Status read clears all flags.
// - Reset pin releases interrupt, blocks access.
// - Wave output picks among thirteen rates.
// - Wave output low when disabled.
// - Four-bit rate field, zero means none.
// - RAM enable follows input when powered.
// - Power failure blocks register writes.
// - Power failure deasserts RAM enable.
// - 114 storage plus 14 clock bytes.
`timescale 1ns/1ps
module rmp_host_port (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic RST_N_I,
  input wire logic POWER_VALID_I,
  input wire logic BUS_STYLE_SELECT_I,
  input wire logic ADDRESS_LATCH_STROBE_I,
  input wire logic TRANSFER_STROBE_I,
  input wire logic DIR_WRITE_STROBE_I,
  input wire logic CHIP_SEL_N_I,
  input wire logic [7:0] SHARED_ADDR_DATA_BUS_I,
  output logic [7:0] SHARED_ADDR_DATA_BUS_O,
  output logic SHARED_ADDR_DATA_BUS_OE_N_O,
  input wire logic ALARM_EVENT_I,
  input wire logic UPDATE_EVENT_I,
  output logic IRQ_N_O,
  output logic IRQ_OE_N_O,
  output logic DIVIDED_WAVE_OUT_O,
  input wire logic RAM_CE_N_I,
  output logic RAM_CE_N_O
);
  import rmp_pkg::*;

  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [SYNC_W-1:0] sync3_q;
  assign pins_raw = {SHARED_ADDR_DATA_BUS_I, ADDRESS_LATCH_STROBE_I, TRANSFER_STROBE_I,
                     DIR_WRITE_STROBE_I, CHIP_SEL_N_I, BUS_STYLE_SELECT_I, RST_N_I,
                     POWER_VALID_I, RAM_CE_N_I};
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  logic [7:0] ad_s;
  logic als_s, ts_s, rw_s, cs_n_s, style_s, rst_pin_n_s, pwr_s, ce_n_s;
  assign {ad_s, als_s, ts_s, rw_s, cs_n_s, style_s, rst_pin_n_s, pwr_s, ce_n_s} = sync2_q;
  logic als_fall, ts_fall, ts_rise, rw_rise;
  assign als_fall = sync3_q[7] & ~als_s;
  assign ts_fall = sync3_q[6] & ~ts_s;
  assign ts_rise = ~sync3_q[6] & ts_s;
  assign rw_rise = ~sync3_q[5] & rw_s;

  logic [7:0] mem_q [MEM_BYTES];
  logic [7:0] mode_q;
  logic [7:0] event_q;
  logic [ADDR_W-1:0] addr_q;
  logic addr_valid_q;
  rmp_xfer_t xfer_q;

  // reset pin locks out the bus
  logic access_ok;
  assign access_ok = rst_pin_n_s & addr_valid_q & ~cs_n_s;

  // style steers the strobe decode; direction level
  logic rd_start, rd_end, wr_evt;
  always_comb begin
    if (style_s) begin
      rd_start = access_ok & ts_rise & rw_s & (xfer_q == XFER_IDLE);
      rd_end = ts_fall | ~rst_pin_n_s;
      wr_evt = access_ok & ts_fall & ~rw_s;
    end else begin
      rd_start = access_ok & ts_fall & (xfer_q == XFER_IDLE);
      rd_end = ts_rise | ~rst_pin_n_s;
      wr_evt = access_ok & rw_rise;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      addr_q <= '0;
    end else if (als_fall) begin
      addr_q <= ad_s[ADDR_W-1:0];
    end
  end

  // data phase needs a fresh address
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      addr_valid_q <= 1'b0;
    end else if (als_fall) begin
      addr_valid_q <= 1'b1;
    end else if (wr_evt || (xfer_q == XFER_READ && rd_end)) begin
      addr_valid_q <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      xfer_q <= XFER_IDLE;
    end else begin
      unique case (xfer_q)
        XFER_IDLE: begin
          if (rd_start) begin
            xfer_q <= XFER_READ;
          end
        end
        XFER_READ: begin
          if (rd_end) begin
            xfer_q <= XFER_IDLE;
          end
        end
        default: xfer_q <= XFER_IDLE;
      endcase
    end
  end

  logic [7:0] rd_data;
  always_comb begin
    if (addr_q == MODE_CTRL_ADDR) begin
      rd_data = mode_q;
    end else if (addr_q == EVENT_STAT_ADDR) begin
      rd_data = event_q;
    end else begin
      rd_data = mem_q[addr_q];
    end
  end

  // Data captured at read start so a flag clear cannot tear the byte
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      SHARED_ADDR_DATA_BUS_O <= 8'h00;
      SHARED_ADDR_DATA_BUS_OE_N_O <= 1'b1;
    end else begin
      if (rd_start) begin
        SHARED_ADDR_DATA_BUS_O <= rd_data;
      end
      SHARED_ADDR_DATA_BUS_OE_N_O <= ~(rd_start | (xfer_q == XFER_READ && !rd_end));
    end
  end

  logic wr_ok;
  assign wr_ok = wr_evt & pwr_s;
  always_ff @(posedge CORE_CLK_I) begin
    if (wr_ok && addr_q != MODE_CTRL_ADDR && addr_q != EVENT_STAT_ADDR) begin
      mem_q[addr_q] <= ad_s;
    end
  end

  // Enables cleared by the reset pin, as the mode byte must be safe on boot
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      mode_q <= 8'h00;
    end else if (!rst_pin_n_s) begin
      mode_q <= mode_q & MODE_RESET_MASK;
    end else if (wr_ok && addr_q == MODE_CTRL_ADDR) begin
      mode_q <= ad_s;
    end
  end

  // Timebase: fractional accumulator gives a 32.768 kHz enable pulse
  logic [24:0] phase_q;
  logic [24:0] phase_sum;
  logic osc_tick;
  logic [DIV_W-1:0] div_q;
  assign phase_sum = phase_q + PHASE_STEP;
  assign osc_tick = phase_sum >= PHASE_WRAP;
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      phase_q <= '0;
      div_q <= '0;
    end else begin
      phase_q <= osc_tick ? phase_sum - PHASE_WRAP : phase_sum;
      if (osc_tick) begin
        div_q <= div_q + 1'b1;
      end
    end
  end

  // 16:1 selector over thirteen divider taps
  logic [RATE_W-1:0] rate_sel;
  logic tap;
  logic tap_q;
  assign rate_sel = mem_q[RATE_CTRL_ADDR][RATE_LSB +: RATE_W];
  always_comb begin
    unique case (rate_sel)
      4'h0: tap = 1'b0;
      4'h1: tap = div_q[6];
      4'h2: tap = div_q[7];
      default: tap = div_q[rate_sel - 4'h2];
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      DIVIDED_WAVE_OUT_O <= 1'b0;
      tap_q <= 1'b0;
    end else begin
      tap_q <= tap;
      DIVIDED_WAVE_OUT_O <= tap & mode_q[WAVE_EN_BIT];
    end
  end

  // status read clears flags; new events win over the clear
  logic [7:0] ev_set;
  logic [7:0] ev_next;
  logic ev_clr;
  logic irq_pend;
  assign ev_clr = rd_start && addr_q == EVENT_STAT_ADDR;
  always_comb begin
    ev_set = 8'h00;
    ev_set[PER_FLAG_BIT] = tap & ~tap_q;
    ev_set[ALARM_FLAG_BIT] = ALARM_EVENT_I;
    ev_set[UPD_FLAG_BIT] = UPDATE_EVENT_I;
    ev_next = (ev_clr ? 8'h00 : event_q) | ev_set;
    irq_pend = (ev_next[PER_FLAG_BIT] & mode_q[PER_EN_BIT]) |
               (ev_next[ALARM_FLAG_BIT] & mode_q[ALARM_EN_BIT]) |
               (ev_next[UPD_FLAG_BIT] & mode_q[UPD_EN_BIT]);
    ev_next[IRQ_SUM_BIT] = ev_next[IRQ_SUM_BIT] | irq_pend;
  end
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I || !rst_pin_n_s) begin
      event_q <= EVENT_RESET;
    end else begin
      event_q <= ev_next;
    end
  end

  // open-drain interrupt, pin level always low
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      IRQ_N_O <= 1'b0;
      IRQ_OE_N_O <= 1'b1;
    end else begin
      IRQ_N_O <= 1'b0;
      IRQ_OE_N_O <= ~(rst_pin_n_s & irq_pend);
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      RAM_CE_N_O <= 1'b1;
    end else begin
      RAM_CE_N_O <= pwr_s ? ce_n_s : 1'b1;
    end
  end

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  a_irq_reset_rel: assert property (!rst_pin_n_s |=> IRQ_OE_N_O)
    else $error("interrupt driven during reset pin");
  a_ce_power_fail: assert property (!pwr_s |=> RAM_CE_N_O)
    else $error("RAM enable active on power failure");
  a_ce_follow_in: assert property (pwr_s |=> RAM_CE_N_O == $past(ce_n_s))
    else $error("RAM enable does not follow input");
  a_wave_disabled: assert property (!mode_q[WAVE_EN_BIT] |=> !DIVIDED_WAVE_OUT_O)
    else $error("wave output high while disabled");
  a_addr_capture: assert property (als_fall |=> addr_q == $past(ad_s[ADDR_W-1:0]))
    else $error("address not latched on strobe fall");
  a_sep_read_drive: assert property (
    !style_s && ts_fall && access_ok && xfer_q == XFER_IDLE |=> !SHARED_ADDR_DATA_BUS_OE_N_O)
    else $error("separate style read not driven");
  a_cmb_read_drive: assert property (
    style_s && ts_rise && rw_s && access_ok && xfer_q == XFER_IDLE
    |=> !SHARED_ADDR_DATA_BUS_OE_N_O ##1 (SHARED_ADDR_DATA_BUS_OE_N_O || !ts_fall))
    else $error("combined style read not driven");
  a_stat_read_clr: assert property (ev_clr
    |=> ((event_q & ~$past(ev_set) & 8'h7F) == 8'h00)
    && (event_q[IRQ_SUM_BIT] == 1'b0 || $past(|ev_set)))
    else $error("status read left a flag set");
  a_irq_on_event: assert property (rst_pin_n_s && irq_pend |=> !IRQ_OE_N_O)
    else $error("interrupt not asserted for enabled flag");
  a_irq_read_rel: assert property (ev_clr && ev_set == 8'h00 && rst_pin_n_s |=> IRQ_OE_N_O)
    else $error("status read did not release interrupt");
  a_pwr_write_blk: assert property (wr_evt && !pwr_s
    |=> mem_q[$past(addr_q)] == $past(mem_q[addr_q]))
    else $error("write accepted during power failure");
endmodule : rmp_host_port

//--- verification/rmp_host_bus_model.sv
// Host processor model for the muxed bus: one byte per address/data cycle.
// Assumes the bench calls xfer between falling clock edges only.
`timescale 1ns/1ps
module rmp_host_bus_model (
  input wire logic clk_i,
  input wire logic style_i,
  input wire logic oe_n_i,
  input wire logic [7:0] dev_i,
  output logic als_o,
  output logic ts_o,
  output logic dir_o,
  output logic cs_n_o,
  output logic [7:0] bus_o
);
  logic [7:0] d_q = 8'h00;
  logic en_q = 1'b0;
  // Released bus shows inverse, never a stale value
  assign bus_o = !oe_n_i ? dev_i : (en_q ? d_q : ~d_q);
  initial begin
    als_o = 1'b0;
    ts_o = 1'b1;
    dir_o = 1'b1;
    cs_n_o = 1'b1;
  end
  task step(input int c);
    repeat (c) @(negedge clk_i);
  endtask : step
  task idle;
    ts_o = !style_i;
    dir_o = 1'b1;
    cs_n_o = 1'b1;
    en_q = 1'b0;
  endtask : idle
  task xfer(input logic wr, input logic [7:0] a, input logic [7:0] wd, input logic sel_n,
            output logic [7:0] rd, output logic ok);
    ok = 1'b0;
    rd = 8'h00;
    dir_o = style_i ? !wr : 1'b1;
    d_q = a;
    en_q = 1'b1;
    als_o = 1'b1;
    step(4);
    als_o = 1'b0;
    step(4);
    cs_n_o = sel_n;
    d_q = wd;
    en_q = wr;
    if (style_i) ts_o = 1'b1;
    else if (wr) dir_o = 1'b0;
    else ts_o = 1'b0;
    for (int i = 0; i < 8; i++) begin
      step(1);
      if (oe_n_i === 1'b0 && !ok) begin
        ok = 1'b1;
        rd = dev_i;
      end
    end
    // combined write keeps direction low through the strobe fall
    ts_o = !style_i;
    if (!style_i) dir_o = 1'b1;
    step(6);
    idle();
    step(1);
  endtask : xfer
endmodule : rmp_host_bus_model

//--- verification/tb_rmp_host_port.sv
// Directed bench for the muxed host bus port, one task per scenario.
// Assumes the host bus model resolves the shared bus for the port.
`timescale 1ns/1ps
module tb_rmp_host_port;
  import rmp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rst_n = 1'b1;
  logic pwr = 1'b1;
  logic style = 1'b0;
  logic alarm = 1'b0;
  logic upd = 1'b0;
  logic ce_n = 1'b1;
  logic als, ts, dir, cs_n, ad_oe_n, irq_n, irq_oe_n, wave, ram_ce_n, ok;
  logic [7:0] bus, ad_o, rd;
  int err_count = 0;
  int check_count = 0;
  int n;
  always #20 clk = ~clk;
  rmp_host_port i_rmp_host_port (.CORE_CLK_I(clk), .RST_I(rst), .RST_N_I(rst_n),
    .POWER_VALID_I(pwr), .BUS_STYLE_SELECT_I(style), .ADDRESS_LATCH_STROBE_I(als),
    .TRANSFER_STROBE_I(ts), .DIR_WRITE_STROBE_I(dir), .CHIP_SEL_N_I(cs_n),
    .SHARED_ADDR_DATA_BUS_I(bus), .SHARED_ADDR_DATA_BUS_O(ad_o),
    .SHARED_ADDR_DATA_BUS_OE_N_O(ad_oe_n), .ALARM_EVENT_I(alarm), .UPDATE_EVENT_I(upd),
    .IRQ_N_O(irq_n), .IRQ_OE_N_O(irq_oe_n), .DIVIDED_WAVE_OUT_O(wave),
    .RAM_CE_N_I(ce_n), .RAM_CE_N_O(ram_ce_n));
  rmp_host_bus_model i_rmp_host_bus_model (.clk_i(clk), .style_i(style), .oe_n_i(ad_oe_n),
    .dev_i(ad_o), .als_o(als), .ts_o(ts), .dir_o(dir), .cs_n_o(cs_n), .bus_o(bus));
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task step(input int c);
    repeat (c) @(negedge clk);
  endtask : step
  task wr(input logic [7:0] a, input logic [7:0] d);
    i_rmp_host_bus_model.xfer(1'b1, a, d, 1'b0, rd, ok);
  endtask : wr
  task rdc(input logic [7:0] a, input logic sel_n, input logic [7:0] exp, input logic eok);
    i_rmp_host_bus_model.xfer(1'b0, a, 8'h00, sel_n, rd, ok);
    chk({7'h00, ok}, {7'h00, eok});
    if (eok) chk(rd, exp);
  endtask : rdc
  task pulse(input logic u);
    if (u) upd = 1'b1;
    else alarm = 1'b1;
    step(1);
    upd = 1'b0;
    alarm = 1'b0;
    step(4);
  endtask : pulse
  task rises(input int c);
    logic w;
    n = 0;
    w = wave;
    repeat (c) begin
      step(1);
      if (wave === 1'b1 && w === 1'b0) n++;
      w = wave;
    end
  endtask : rises
  task do_reset;
    rst = 1'b1;
    step(10);
    rst = 1'b0;
    step(4);
  endtask : do_reset
  task t_sep;
    chk({7'h00, ad_oe_n}, 8'h01);
    wr(8'h20, 8'hA5);
    wr(8'h7F, 8'h5A);
    rdc(8'h20, 1'b0, 8'hA5, 1'b1);
    rdc(8'h7F, 1'b0, 8'h5A, 1'b1);
    rdc(8'h20, 1'b1, 8'h00, 1'b0);
  endtask : t_sep
  task t_pwr;
    ce_n = 1'b0;
    step(6);
    chk({7'h00, ram_ce_n}, 8'h00);
    pwr = 1'b0;
    step(6);
    chk({7'h00, ram_ce_n}, 8'h01);
    wr(8'h20, 8'h11);
    pwr = 1'b1;
    ce_n = 1'b1;
    step(6);
    chk({7'h00, ram_ce_n}, 8'h01);
    rdc(8'h20, 1'b0, 8'hA5, 1'b1);
  endtask : t_pwr
  task t_irq;
    wr(RATE_CTRL_ADDR, 8'h00);
    wr(MODE_CTRL_ADDR, 8'h00);
    i_rmp_host_bus_model.xfer(1'b0, EVENT_STAT_ADDR, 8'h00, 1'b0, rd, ok);
    pulse(1'b1);
    chk({7'h00, irq_oe_n}, 8'h01);
    rdc(EVENT_STAT_ADDR, 1'b0, 8'h10, 1'b1);
    wr(MODE_CTRL_ADDR, 8'h30);
    pulse(1'b1);
    pulse(1'b0);
    chk({6'h00, irq_n, irq_oe_n}, 8'h00);
    rdc(EVENT_STAT_ADDR, 1'b0, 8'hB0, 1'b1);
    chk({7'h00, irq_oe_n}, 8'h01);
    rdc(EVENT_STAT_ADDR, 1'b0, 8'h00, 1'b1);
  endtask : t_irq
  task t_rst_pin;
    pulse(1'b1);
    chk({7'h00, irq_oe_n}, 8'h00);
    rst_n = 1'b0;
    step(4);
    chk({7'h00, irq_oe_n}, 8'h01);
    rdc(8'h20, 1'b0, 8'h00, 1'b0);
    rst_n = 1'b1;
    step(4);
    rdc(MODE_CTRL_ADDR, 1'b0, 8'h00, 1'b1);
  endtask : t_rst_pin
  task t_wave;
    wr(RATE_CTRL_ADDR, 8'h03);
    rises(8000);
    chk(8'(n), 8'h00);
    chk({7'h00, wave}, 8'h00);
    wr(RATE_CTRL_ADDR, 8'h00);
    wr(MODE_CTRL_ADDR, 8'h08);
    rises(8000);
    chk(8'(n), 8'h00);
    wr(RATE_CTRL_ADDR, 8'h03);
    rises(8000);
    chk({7'h00, n == 2 || n == 3}, 8'h01);
    wr(RATE_CTRL_ADDR, 8'h04);
    rises(8000);
    chk({7'h00, n == 1 || n == 2}, 8'h01);
    wr(MODE_CTRL_ADDR, 8'h48);
    chk({7'h00, irq_oe_n}, 8'h00);
    rdc(EVENT_STAT_ADDR, 1'b0, 8'hC0, 1'b1);
  endtask : t_wave
  task t_comb;
    rst = 1'b1;
    step(1);
    style = 1'b1;
    i_rmp_host_bus_model.idle();
    do_reset();
    wr(8'h30, 8'h3C);
    rdc(8'h30, 1'b0, 8'h3C, 1'b1);
    rdc(8'h20, 1'b0, 8'hA5, 1'b1);
  endtask : t_comb
  task end_sim;
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  initial begin
    do_reset();
    t_sep();
    t_pwr();
    t_irq();
    t_rst_pin();
    t_wave();
    t_comb();
    end_sim();
  end
endmodule : tb_rmp_host_port
